// ===== common/ssrc_pkg.sv
// shared constants and types for the sleep-state resource configuration block
package ssrc_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_FORCE_OFF_A = 6'h29;
  localparam logic [5:0] IDX_FORCE_OFF_B = 6'h2A;
  localparam logic [5:0] IDX_DEFAULT_VOLTAGE_SELECT = 6'h2B;
  localparam logic [5:0] IDX_PIN_MAP = 6'h2C;
  localparam logic [5:0] IDX_STATUS = 6'h3F;
  // resources: 0..7 first linear group, 8..9 second linear group, 10..13 converters
  localparam int unsigned NUM_RES = 14;
  localparam int unsigned NUM_CONV = 4;
  localparam int unsigned CONV_BASE = 10;
  localparam int unsigned NUM_SEL = 4;
  localparam int unsigned NUM_MAP = 4;
  localparam int unsigned MAP_W = 2;
  // field positions
  localparam int unsigned THERM_OFF_BIT = 7;
  localparam int unsigned CLKOUT_OFF_BIT = 6;
  localparam int unsigned GRP_B_RES_W = 6;
  localparam int unsigned LDO_DV_BASE = 4;
  localparam int unsigned ST_SLEEP_BIT = 0;
  localparam int unsigned ST_LOAD_BIT = 1;
  localparam int unsigned ST_STRAP_BIT = 2;
  localparam int unsigned ST_SEL_BASE = 4;
  // values after asynchronous reset, before the default load
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    SSRC_MODE_ACTIVE = 2'b00,
    SSRC_MODE_ECO = 2'b01,
    SSRC_MODE_OFF = 2'b10
  } ssrc_mode_t;

  typedef enum logic [1:0] {
    SSRC_ST_LOAD = 2'b00,
    SSRC_ST_ACTIVE = 2'b01,
    SSRC_ST_SLEEP = 2'b10
  } ssrc_state_t;

  // the four configuration registers, also the layout of the programmed defaults
  typedef struct packed {
    logic [7:0] pin_map;
    logic [7:0] default_voltage_select;
    logic [7:0] force_off_b;
    logic [7:0] force_off_a;
  } ssrc_cfg_t;
endpackage

// ===== core/ssrc_mode_sel.sv
// sleep-state mode decision for one regulator
module ssrc_mode_sel
  import ssrc_pkg::*;
(
  input wire logic in_sleep,
  input wire logic keep_on,
  input wire logic force_off,
  input wire logic forced_mode,
  output ssrc_mode_t mode
);
  // keep-on wins, then force-off, then eco unless forced mode
  always_comb begin
    mode = SSRC_MODE_ACTIVE;
    if (in_sleep) begin
      if (keep_on) begin
        mode = SSRC_MODE_ACTIVE;
      end else if (force_off) begin
        mode = SSRC_MODE_OFF;
      end else if (forced_mode) begin
        mode = SSRC_MODE_ACTIVE;
      end else begin
        mode = SSRC_MODE_ECO;
      end
    end
  end
endmodule

// ===== core/ssrc_sync.sv
// two-stage synchroniser for pin inputs
module ssrc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

// ===== core/ssrc_top.sv
// sleep-state resource configuration registers with APB slave
// Overview of operation
// R1 - force-off set, keep-on clear: off in sleep
// R2 - force-off clear: sleep behaviour follows keep-on and, for converters, forced mode
// R3 - thermal and slow clock sleep bits disable
// R4 - voltage select bit picks operating or alternate register
// R5 - sleep: eco, active or off per table
// R6 - two-bit map picks converter select pin
// R7 - mapped select bit follows chosen pin level
// R8 - fourth regulator map only with strap low
// R9 - power-on reset reloads programmed defaults
// R10 - keep-on clear gives eco unless forced mode
// R11 - apply on sleep entry, restore on exit
//
// The APB slave port was chosen for this implementation.
module ssrc_top
  import ssrc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ssrc_cfg_t otp_defaults,
  input wire logic [NUM_RES-1:0] keep_on,
  input wire logic [NUM_CONV-1:0] converter_forced_mode_bit,
  input wire logic sleep_pin,
  input wire logic [NUM_SEL-1:0] converter_voltage_select_pin,
  input wire logic config_strap_two,
  output ssrc_mode_t [NUM_RES-1:0] resource_mode,
  output logic [7:0] default_voltage_source,
  output logic thermal_monitor_en,
  output logic slow_clock_out_en,
  output logic sleep_active
);
  ssrc_state_t state_ff, nxt_state;
  ssrc_cfg_t cfg_ff, nxt_cfg;
  ssrc_mode_t [NUM_RES-1:0] mode_ff, nxt_mode;
  logic therm_en_ff, nxt_therm_en;
  logic clkout_en_ff, nxt_clkout_en;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic sleep_s;
  logic strap_s;
  logic [NUM_SEL-1:0] sel_s;
  logic [5:0] idx;
  logic aligned;
  logic wr_ok;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic in_sleep;
  logic [NUM_RES-1:0] force_off_vec;
  logic [NUM_RES-1:0] forced_vec;
  logic settle_ff, nxt_settle;
  logic sleep_ff, nxt_sleep;

  // pin inputs cross into the bus clock
  ssrc_sync #(.W(NUM_SEL + 2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({converter_voltage_select_pin, config_strap_two, sleep_pin}),
    .q({sel_s, strap_s, sleep_s})
  );

  // address decode
  assign idx = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign wr_ok = psel && penable && pready_ff && pwrite && aligned && pstrb[0]
    && (state_ff != SSRC_ST_LOAD);
  assign in_sleep = (state_ff == SSRC_ST_SLEEP);
  assign force_off_vec = {cfg_ff.force_off_b[GRP_B_RES_W-1:0], cfg_ff.force_off_a};
  assign forced_vec = {converter_forced_mode_bit, {CONV_BASE{1'b0}}};

  // read mux
  always_comb begin
    rd_byte = CFG_RESET;
    rd_hit = 1'b1;
    unique case (idx)
      IDX_FORCE_OFF_A: rd_byte = cfg_ff.force_off_a;
      IDX_FORCE_OFF_B: rd_byte = cfg_ff.force_off_b;
      IDX_DEFAULT_VOLTAGE_SELECT: rd_byte = cfg_ff.default_voltage_select;
      IDX_PIN_MAP: rd_byte = cfg_ff.pin_map;
      IDX_STATUS: begin
        rd_byte[ST_SLEEP_BIT] = in_sleep;
        rd_byte[ST_LOAD_BIT] = (state_ff == SSRC_ST_LOAD);
        rd_byte[ST_STRAP_BIT] = strap_s;
        rd_byte[ST_SEL_BASE +: NUM_SEL] = sel_s;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // apb answer: registered, one access cycle
  always_comb begin
    nxt_pready = 1'b0;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    if (psel && !penable && !pready_ff) begin
      nxt_pready = 1'b1;
      nxt_prdata = {24'h00_0000, rd_byte};
      nxt_pslverr = !aligned || !rd_hit || (pwrite && idx == IDX_STATUS);
      if (pwrite || !aligned || !rd_hit) begin
        nxt_prdata = RDATA_RESET;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= RDATA_RESET;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= nxt_pready;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // sleep sequencer; loading spans two edges so synced pins hold real levels first
  always_comb begin
    nxt_state = state_ff;
    nxt_settle = 1'b1;
    unique case (state_ff)
      // R9 - leave loading once synced pins settle
      SSRC_ST_LOAD: if (settle_ff) nxt_state = SSRC_ST_ACTIVE;
      // R11 - enter and leave sleep
      SSRC_ST_ACTIVE: if (sleep_s) nxt_state = SSRC_ST_SLEEP;
      SSRC_ST_SLEEP: if (!sleep_s) nxt_state = SSRC_ST_ACTIVE;
      default: nxt_state = SSRC_ST_LOAD;
    endcase
    nxt_sleep = (nxt_state == SSRC_ST_SLEEP);
  end

  // configuration registers
  always_comb begin
    nxt_cfg = cfg_ff;
    if (state_ff == SSRC_ST_LOAD) begin
      // R9 - reload programmed defaults
      nxt_cfg = otp_defaults;
    end else begin
      if (wr_ok) begin
        unique case (idx)
          IDX_FORCE_OFF_A: nxt_cfg.force_off_a = pwdata[7:0];
          IDX_FORCE_OFF_B: nxt_cfg.force_off_b = pwdata[7:0];
          // R4 - software picks voltage register
          IDX_DEFAULT_VOLTAGE_SELECT: nxt_cfg.default_voltage_select = pwdata[7:0];
          IDX_PIN_MAP: nxt_cfg.pin_map = pwdata[7:0];
          default: nxt_cfg = cfg_ff;
        endcase
      end
      for (int i = 0; i < NUM_MAP; i++) begin
        // R8 - fourth map needs strap low
        if (i < NUM_MAP - 1 || !strap_s) begin
          // R6 R7 - mapped pin drives select bit
          nxt_cfg.default_voltage_select[LDO_DV_BASE + i] = sel_s[nxt_cfg.pin_map[i*MAP_W +: MAP_W]];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SSRC_ST_LOAD;
      cfg_ff <= {4{CFG_RESET}};
      settle_ff <= 1'b0;
      sleep_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cfg_ff <= nxt_cfg;
      settle_ff <= nxt_settle;
      sleep_ff <= nxt_sleep;
    end
  end

  // per-regulator sleep decision
  for (genvar g = 0; g < NUM_RES; g++) begin : g_mode
    // R1 R2 R5 R10 - mode from keep-on, force-off, forced mode
    ssrc_mode_sel u_mode (
      .in_sleep(in_sleep),
      .keep_on(keep_on[g]),
      .force_off(force_off_vec[g]),
      .forced_mode(forced_vec[g]),
      .mode(nxt_mode[g])
    );
  end

  // R3 - thermal monitor and slow clock sleep switches
  always_comb begin
    nxt_therm_en = !(in_sleep && cfg_ff.force_off_b[THERM_OFF_BIT]);
    nxt_clkout_en = !(in_sleep && cfg_ff.force_off_b[CLKOUT_OFF_BIT]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= {NUM_RES{SSRC_MODE_ACTIVE}};
      therm_en_ff <= 1'b1;
      clkout_en_ff <= 1'b1;
    end else begin
      mode_ff <= nxt_mode;
      therm_en_ff <= nxt_therm_en;
      clkout_en_ff <= nxt_clkout_en;
    end
  end

  // outputs straight from flip-flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign resource_mode = mode_ff;
  assign default_voltage_source = cfg_ff.default_voltage_select;
  assign thermal_monitor_en = therm_en_ff;
  assign slow_clock_out_en = clkout_en_ff;
  assign sleep_active = sleep_ff;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_off_when_forced: // R1
    assert property (in_sleep && force_off_vec[0] && !keep_on[0]
      |=> mode_ff[0] == SSRC_MODE_OFF)
    else $error("forced-off regulator not off in sleep");

  a_keep_on_follow: // R2
    assert property (in_sleep && !force_off_vec[1] && keep_on[1]
      |=> mode_ff[1] == SSRC_MODE_ACTIVE)
    else $error("keep-on regulator not active in sleep");

  a_thermal_sleep_off: // R3
    assert property (in_sleep && cfg_ff.force_off_b[THERM_OFF_BIT]
      |=> !therm_en_ff && slow_clock_out_en == !$past(cfg_ff.force_off_b[CLKOUT_OFF_BIT]))
    else $error("thermal monitor not off in sleep");

  a_vsel_write: // R4
    assert property (wr_ok && idx == IDX_DEFAULT_VOLTAGE_SELECT
      |=> default_voltage_source[3:0] == $past(pwdata[3:0]))
    else $error("converter voltage select not written");

  a_eco_default: // R5
    assert property (in_sleep && !force_off_vec[2] && !keep_on[2]
      |=> mode_ff[2] == SSRC_MODE_ECO)
    else $error("regulator not in low-power mode");

  a_pin_map_follow: // R7
    assert property (state_ff != SSRC_ST_LOAD && nxt_cfg.pin_map[1:0] == 2'b01
      |=> default_voltage_source[LDO_DV_BASE] == $past(sel_s[1]))
    else $error("mapped select bit does not follow pin");

  a_strap_blocks_map: // R8
    assert property (state_ff != SSRC_ST_LOAD && strap_s && !wr_ok
      |=> $stable(default_voltage_source[7]))
    else $error("fourth map active with strap high");

  a_reload_defaults: // R9
    assert property (state_ff == SSRC_ST_LOAD
      |=> cfg_ff == $past(otp_defaults)
        && state_ff == ($past(settle_ff) ? SSRC_ST_ACTIVE : SSRC_ST_LOAD))
    else $error("defaults not loaded after reset");

  a_forced_mode_conv: // R10
    assert property (in_sleep && !keep_on[CONV_BASE] && !force_off_vec[CONV_BASE]
      && converter_forced_mode_bit[0] |=> mode_ff[CONV_BASE] == SSRC_MODE_ACTIVE)
    else $error("forced-mode converter entered low-power mode");

  a_restore_active: // R11
    assert property (state_ff == SSRC_ST_ACTIVE
      |=> mode_ff == {NUM_RES{SSRC_MODE_ACTIVE}} && therm_en_ff && clkout_en_ff)
    else $error("resources not restored outside sleep");

  a_clkout_sleep_off: // R3
    assert property (in_sleep && cfg_ff.force_off_b[CLKOUT_OFF_BIT]
      |=> !slow_clock_out_en)
    else $error("slow clock output not off in sleep");

  a_keep_on_wins: // R5
    assert property (in_sleep && keep_on[3] && force_off_vec[3]
      |=> mode_ff[3] == SSRC_MODE_ACTIVE)
    else $error("keep-on regulator not active despite force-off");

  a_off_beats_forced: // R5
    assert property (in_sleep && !keep_on[CONV_BASE + 1] && force_off_vec[CONV_BASE + 1]
      |=> mode_ff[CONV_BASE + 1] == SSRC_MODE_OFF)
    else $error("forced-off converter not off in sleep");

  a_map_third_follow: // R6
    assert property (state_ff != SSRC_ST_LOAD && nxt_cfg.pin_map[5:4] == 2'b10
      |=> default_voltage_source[LDO_DV_BASE + 2] == $past(sel_s[2]))
    else $error("third mapped select bit does not follow pin");

  a_map_fourth_follow: // R8
    assert property (state_ff != SSRC_ST_LOAD && !strap_s && nxt_cfg.pin_map[7:6] == 2'b11
      |=> default_voltage_source[LDO_DV_BASE + 3] == $past(sel_s[3]))
    else $error("fourth mapped select bit does not follow pin with strap low");

  c_sleep_entry: cover property (state_ff == SSRC_ST_ACTIVE ##1 in_sleep);
  c_reg_off: cover property (mode_ff[0] == SSRC_MODE_OFF);
  c_reg_eco: cover property (mode_ff[CONV_BASE] == SSRC_MODE_ECO);
  c_sleep_exit: cover property (in_sleep ##1 state_ff == SSRC_ST_ACTIVE);
  c_map_fourth: cover property (!strap_s && state_ff == SSRC_ST_ACTIVE && default_voltage_source[7]);
endmodule

// ===== tb/ssrc_top_test.sv
// self-checking bench for the sleep-state resource configuration block
module ssrc_top_test
  import ssrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, sleep_pin, config_strap_two, err;
  logic pready, pslverr, thermal_monitor_en, slow_clock_out_en, sleep_active;
  logic [7:0] paddr, default_voltage_source, m, v;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, converter_forced_mode_bit, converter_voltage_select_pin, fm, p;
  logic [NUM_RES-1:0] keep_on, ko, fo;
  logic [1:0] tb;
  ssrc_cfg_t otp_defaults;
  ssrc_mode_t [NUM_RES-1:0] resource_mode;
  int num_errors = 0;
  int comparisons = 0;
  int seed = 20;

  ssrc_top ssrc_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .otp_defaults(otp_defaults), .keep_on(keep_on),
    .converter_forced_mode_bit(converter_forced_mode_bit), .sleep_pin(sleep_pin),
    .converter_voltage_select_pin(converter_voltage_select_pin),
    .config_strap_two(config_strap_two), .resource_mode(resource_mode),
    .default_voltage_source(default_voltage_source),
    .thermal_monitor_en(thermal_monitor_en), .slow_clock_out_en(slow_clock_out_en),
    .sleep_active(sleep_active)
  );

  // free-running 20 MHz clock
  always #25 pclk = ~pclk;

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits for pready as long as it takes, the watchdog bounds the run
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, {idx, 2'b00}, {24'hA5A5A5, d}, 4'hF);
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, {idx, 2'b00}, 32'h0, 4'hF);
    chk(rd, {24'h0, exp});
    chk({31'h0, err}, 32'h0);
  endtask

  // select bits: pins override the mapped regulator bits
  function automatic logic [7:0] exp_dv(input logic [7:0] sw, input logic [7:0] mp);
    logic [7:0] r;
    r = sw;
    for (int k = 0; k < 3; k++) r[LDO_DV_BASE+k] = converter_voltage_select_pin[mp[2*k+:2]];
    if (!config_strap_two) r[7] = converter_voltage_select_pin[mp[7:6]];
    return r;
  endfunction

  function automatic logic [31:0] exp_modes(input logic sl);
    ssrc_mode_t [NUM_RES-1:0] e;
    for (int i = 0; i < NUM_RES; i++) begin
      if (!sl || ko[i]) e[i] = SSRC_MODE_ACTIVE;
      else if (fo[i]) e[i] = SSRC_MODE_OFF;
      else if (i >= CONV_BASE && fm[i-CONV_BASE]) e[i] = SSRC_MODE_ACTIVE;
      else e[i] = SSRC_MODE_ECO;
    end
    return 32'(e);
  endfunction

  task automatic rst;
    @(posedge pclk);
    presetn <= 1'b0;
    otp_defaults <= ssrc_cfg_t'($random(seed));
    @(posedge pclk);
    chk({29'h0, thermal_monitor_en, slow_clock_out_en, sleep_active}, 32'h6);
    repeat (14) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rchk(IDX_FORCE_OFF_A, otp_defaults.force_off_a);
    rchk(IDX_FORCE_OFF_B, otp_defaults.force_off_b);
    rchk(IDX_PIN_MAP, otp_defaults.pin_map);
    rchk(IDX_DEFAULT_VOLTAGE_SELECT, exp_dv(otp_defaults.default_voltage_select, otp_defaults.pin_map));
    $display("reset load test done");
  endtask

  task automatic sleep_set(input logic s);
    int n;
    n = 0;
    @(posedge pclk);
    sleep_pin <= s;
    do begin
      @(posedge pclk);
      n++;
    end while (sleep_active !== s && n < 12);
    // two sync stages and the state register: seen on the fourth edge
    chk({27'h0, n[3:0], sleep_active}, {27'h0, 4'h4, s});
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, sleep_pin, config_strap_two} = 5'h00;
    {paddr, pwdata, pstrb, otp_defaults} = '0;
    {keep_on, converter_forced_mode_bit, converter_voltage_select_pin} = '0;
    rst();
    // every map code in every field, both strap levels, pins toggled
    for (int i = 0; i < 8; i++) begin
      m = {2'(i + 3), 2'(i + 2), 2'(i + 1), 2'(i)};
      v = 8'($random(seed));
      @(posedge pclk);
      converter_voltage_select_pin <= 4'($random(seed));
      config_strap_two <= i[0];
      wreg(IDX_PIN_MAP, m);
      wreg(IDX_DEFAULT_VOLTAGE_SELECT, v);
      repeat (4) @(posedge pclk);
      rchk(IDX_PIN_MAP, m);
      rchk(IDX_DEFAULT_VOLTAGE_SELECT, exp_dv(v, m));
      chk(32'(default_voltage_source), 32'(exp_dv(v, m)));
      p = ~converter_voltage_select_pin;
      converter_voltage_select_pin <= p;
      repeat (4) @(posedge pclk);
      chk(32'(default_voltage_source), 32'(exp_dv(v, m)));
    end
    $display("pin mapping test done");
    // sleep outcomes; first two passes are forced corners
    for (int i = 0; i < 10; i++) begin
      ko = i < 2 ? {NUM_RES{i[0]}} : NUM_RES'($random(seed));
      fo = i < 2 ? '1 : NUM_RES'($random(seed));
      fm = i < 2 ? 4'hF : 4'($random(seed));
      tb = 2'($random(seed));
      wreg(IDX_FORCE_OFF_A, fo[7:0]);
      wreg(IDX_FORCE_OFF_B, {tb, fo[13:8]});
      @(posedge pclk);
      keep_on <= ko;
      converter_forced_mode_bit <= fm;
      sleep_set(1'b1);
      chk(32'(resource_mode), exp_modes(1'b1));
      chk({30'h0, thermal_monitor_en, slow_clock_out_en}, {30'h0, ~tb});
      sleep_set(1'b0);
      chk(32'(resource_mode), exp_modes(1'b0));
      chk({30'h0, thermal_monitor_en, slow_clock_out_en}, 32'h3);
    end
    $display("sleep mode test done");
    // refused accesses and a write with the low strobe clear
    apb(1'b0, 8'h00, 32'h0, 4'hF);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b0, 8'hA5, 32'h0, 4'hF);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, {IDX_STATUS, 2'b00}, 32'hFF, 4'hF);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, {IDX_PIN_MAP, 2'b00}, 32'h5A, 4'hE);
    rchk(IDX_PIN_MAP, m);
    rchk(IDX_STATUS, (8'(p) << ST_SEL_BASE) | (8'(config_strap_two) << ST_STRAP_BIT));
    $display("access error test done");
    rst();
    results();
  end

  // watchdog, far beyond the expected run length
  initial begin
    #500000;
    num_errors++;
    results();
  end
endmodule
